// ===== core/reset_brownout_protect_ctrl.sv
`timescale 1ns/100ps
`include "reset_brownout_protect_ctrl_consts.svh"

module reset_brownout_protect_ctrl #(
    parameter int RST_PULSE_CYC = `RST_PULSE_CYC,
    parameter int BKPT_NUM      = `DBG_BKPT_NUM,
    parameter int WPT_NUM       = `DBG_WPT_NUM
) (
    input  wire logic                                  clk,            // 200 MHz oscillator clock
    input  wire logic                                  arst_n,         // power-on reset, async low
    input  wire logic                                  rst_pin,        // external reset pin level
    input  wire logic                                  wdt_rst_req,    // watchdog reset, same clock
    input  wire logic                                  supply_ok,      // supply at usable level
    input  wire logic                                  sdd_below_rst,  // below reset threshold
    input  wire logic [`SDD_INT_LEVELS-1:0]            sdd_below_int,  // below each irq threshold
    input  wire logic [1:0]                            sdd_int_sel,    // chosen irq threshold
    input  wire logic                                  sdd_rst_en,     // supply drop reset enable
    input  wire logic                                  osc_ready,      // oscillator stable
    input  wire logic                                  flash_ready,    // flash init finished
    input  wire logic [31:0]                           prot_word,      // flash protection word
    output logic                                       osc_en,         // start oscillator
    output logic                                       flash_init,     // flash init request
    output logic                                       defaults_load,  // load register defaults
    output logic                                       core_rst_n,     // internal reset, low active
    output logic [31:0]                                boot_addr,      // first fetch address
    output logic                                       sdd_irq,        // to nested_interrupt_ctrl
    output logic                                       sdd_status,     // polled status bit
    output reset_brownout_protect_ctrl_pkg::prot_level_e prot_level,   // protection level
    output reset_brownout_protect_ctrl_pkg::prog_s     prog_ctl,       // loader permissions
    output reset_brownout_protect_ctrl_pkg::dbg_s      dbg_ctl,        // debug port control
    output logic [2:0]                                 bkpt_num,       // hardware breakpoints
    output logic [1:0]                                 wpt_num         // data watchpoints
);

    // ----------------------------------------------------------------
    // pin and analog input synchronisers
    // ----------------------------------------------------------------
    localparam int SYNC_W = 3 + `SDD_INT_LEVELS;

    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] syn_in;
    logic              pin_s;
    logic              supply_s;
    logic              below_rst_s;
    logic [`SDD_INT_LEVELS-1:0] below_int_s;

    assign raw_in = {rst_pin, supply_ok, sdd_below_rst, sdd_below_int};

    // reset pin idles high, so it leaves reset reading high
    sync_chain #(
        .WIDTH   (SYNC_W),
        .RST_VAL (8'h20)
    ) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (raw_in),
        .sync_out (syn_in)
    );

    assign pin_s       = syn_in[SYNC_W-1];
    assign supply_s    = syn_in[SYNC_W-2];
    assign below_rst_s = syn_in[SYNC_W-3];
    assign below_int_s = syn_in[`SDD_INT_LEVELS-1:0];

    // ----------------------------------------------------------------
    // reset pin low-time filter
    // ----------------------------------------------------------------
    logic [`RST_CNT_W-1:0] low_cnt_r;
    logic [`RST_CNT_W-1:0] low_cnt_nxt;
    logic                  pin_req;

    localparam logic [`RST_CNT_W-1:0] PULSE_CNT = RST_PULSE_CYC[`RST_CNT_W-1:0];

    // short glitches never reach the count, so they do not reset the chip
    always_comb begin
        low_cnt_nxt = low_cnt_r;
        if (pin_s) begin
            low_cnt_nxt = '0;
        end else if (low_cnt_r != PULSE_CNT) begin
            low_cnt_nxt = low_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt_r <= '0;
        end else begin
            low_cnt_r <= low_cnt_nxt;
        end
    end

    assign pin_req = (low_cnt_r == PULSE_CNT);

    // ----------------------------------------------------------------
    // reset merge and release synchroniser
    // ----------------------------------------------------------------
    logic       hold_req_r;
    logic       hold_req_nxt;
    logic       rel_sync_r;
    logic       rel_sync_nxt;
    logic       chip_rst_n_r;
    logic       chip_rst_n_nxt;
    logic       merge_rst_n;

    // any source requests reset; supply drop only when enabled
    always_comb begin
        hold_req_nxt = pin_req | wdt_rst_req
                     | (sdd_rst_en & below_rst_s);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_req_r <= 1'b0;
        end else begin
            hold_req_r <= hold_req_nxt;
        end
    end

    // request is a flop output, so the async clear is glitch free
    assign merge_rst_n = arst_n & ~hold_req_r;

    always_comb begin
        rel_sync_nxt   = 1'b1;
        chip_rst_n_nxt = rel_sync_r;
    end

    // assert at once, release two edges later on the clock
    always_ff @(posedge clk or negedge merge_rst_n) begin
        if (!merge_rst_n) begin
            rel_sync_r   <= 1'b0;
            chip_rst_n_r <= 1'b0;
        end else begin
            rel_sync_r   <= rel_sync_nxt;
            chip_rst_n_r <= chip_rst_n_nxt;
        end
    end

    // ----------------------------------------------------------------
    // power-up sequencer
    // ----------------------------------------------------------------
    reset_brownout_protect_ctrl_pkg::seq_state_e st_r;
    reset_brownout_protect_ctrl_pkg::seq_state_e st_nxt;
    logic        osc_en_r;
    logic        osc_en_nxt;
    logic        flash_init_r;
    logic        flash_init_nxt;
    logic        load_r;
    logic        load_nxt;
    logic        core_rst_n_r;
    logic        core_rst_n_nxt;
    logic [31:0] boot_addr_r;
    logic [31:0] boot_addr_nxt;
    logic        word_take;

    // oscillator and flash start even while chip reset is still held
    always_comb begin
        st_nxt         = st_r;
        osc_en_nxt     = osc_en_r;
        flash_init_nxt = 1'b0;
        load_nxt       = 1'b0;
        core_rst_n_nxt = core_rst_n_r;
        boot_addr_nxt  = boot_addr_r;
        word_take      = 1'b0;
        case (st_r)
            reset_brownout_protect_ctrl_pkg::SQ_WAIT_SUPPLY: begin
                core_rst_n_nxt = 1'b0;
                if (supply_s) begin                            // release chain may already be open
                    osc_en_nxt = 1'b1;
                    st_nxt     = reset_brownout_protect_ctrl_pkg::SQ_OSC_START;
                end
            end
            reset_brownout_protect_ctrl_pkg::SQ_OSC_START: begin
                if (osc_ready) begin
                    flash_init_nxt = 1'b1;
                    st_nxt         = reset_brownout_protect_ctrl_pkg::SQ_FLASH_INIT;
                end
            end
            reset_brownout_protect_ctrl_pkg::SQ_FLASH_INIT: begin
                flash_init_nxt = ~flash_ready;
                if (flash_ready) begin
                    word_take = 1'b1;
                    st_nxt    = reset_brownout_protect_ctrl_pkg::SQ_LOAD;
                end
            end
            reset_brownout_protect_ctrl_pkg::SQ_LOAD: begin
                // defaults land one edge before the core leaves reset
                if (chip_rst_n_r) begin
                    load_nxt       = 1'b1;
                    boot_addr_nxt  = `BOOT_FETCH_ADDR;
                    st_nxt         = reset_brownout_protect_ctrl_pkg::SQ_RUN;
                end
            end
            reset_brownout_protect_ctrl_pkg::SQ_RUN: begin
                core_rst_n_nxt = 1'b1;
                if (!chip_rst_n_r) begin
                    core_rst_n_nxt = 1'b0;
                    st_nxt         = reset_brownout_protect_ctrl_pkg::SQ_WAIT_SUPPLY;
                end
            end
            default: begin
                st_nxt = reset_brownout_protect_ctrl_pkg::SQ_WAIT_SUPPLY;
            end
        endcase
        // supply loss, or a new reset outside SQ_OSC_START and SQ_FLASH_INIT, restarts the sequence; osc_en stays on
        if (!supply_s || (!chip_rst_n_r && st_r != reset_brownout_protect_ctrl_pkg::SQ_OSC_START
                          && st_r != reset_brownout_protect_ctrl_pkg::SQ_FLASH_INIT)) begin
            if (st_r != reset_brownout_protect_ctrl_pkg::SQ_WAIT_SUPPLY) begin
                st_nxt         = reset_brownout_protect_ctrl_pkg::SQ_WAIT_SUPPLY;
                core_rst_n_nxt = 1'b0;
                flash_init_nxt = 1'b0;
                load_nxt       = 1'b0;
                word_take      = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r         <= reset_brownout_protect_ctrl_pkg::SQ_WAIT_SUPPLY;
            osc_en_r     <= 1'b0;
            flash_init_r <= 1'b0;
            load_r       <= 1'b0;
            core_rst_n_r <= 1'b0;
            boot_addr_r  <= `BOOT_FETCH_ADDR;
        end else begin
            st_r         <= st_nxt;
            osc_en_r     <= osc_en_nxt;
            flash_init_r <= flash_init_nxt;
            load_r       <= load_nxt;
            core_rst_n_r <= core_rst_n_nxt;
            boot_addr_r  <= boot_addr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // code protection decode
    // ----------------------------------------------------------------
    reset_brownout_protect_ctrl_pkg::prot_level_e lvl_r;
    reset_brownout_protect_ctrl_pkg::prot_level_e lvl_nxt;
    logic                                         nopin_r;
    logic                                         nopin_nxt;
    reset_brownout_protect_ctrl_pkg::prog_s       prog_r;
    reset_brownout_protect_ctrl_pkg::prog_s       prog_nxt;

    // unknown words leave the part open; only exact patterns protect
    always_comb begin
        lvl_nxt   = lvl_r;
        nopin_nxt = nopin_r;
        if (word_take) begin
            nopin_nxt = (prot_word == `PROT_NOPIN_PATTERN);
            case (prot_word)
                `PROT_ONE_PATTERN:   lvl_nxt = reset_brownout_protect_ctrl_pkg::PROT_ONE;
                `PROT_TWO_PATTERN:   lvl_nxt = reset_brownout_protect_ctrl_pkg::PROT_TWO;
                `PROT_THREE_PATTERN: lvl_nxt = reset_brownout_protect_ctrl_pkg::PROT_THREE;
                default:             lvl_nxt = reset_brownout_protect_ctrl_pkg::PROT_NONE;
            endcase
        end
        prog_nxt.app_prog_ok  = 1'b1;
        prog_nxt.pin_entry_en = ~nopin_nxt;
        case (lvl_nxt)
            reset_brownout_protect_ctrl_pkg::PROT_ONE: begin
                prog_nxt.cmd_class = reset_brownout_protect_ctrl_pkg::PROG_NO_SECTOR0;
            end
            reset_brownout_protect_ctrl_pkg::PROT_TWO: begin
                prog_nxt.cmd_class = reset_brownout_protect_ctrl_pkg::PROG_ERASE_ALL_ONLY;
            end
            reset_brownout_protect_ctrl_pkg::PROT_THREE: begin
                prog_nxt.cmd_class    = reset_brownout_protect_ctrl_pkg::PROG_NONE;
                prog_nxt.pin_entry_en = 1'b0;
            end
            default: begin
                prog_nxt.cmd_class = reset_brownout_protect_ctrl_pkg::PROG_ALL;
            end
        endcase
    end

    // locked down until the flash word has been read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lvl_r   <= reset_brownout_protect_ctrl_pkg::PROT_THREE;
            nopin_r <= 1'b1;
            prog_r  <= '{pin_entry_en: 1'b0, app_prog_ok: 1'b1,
                         cmd_class: reset_brownout_protect_ctrl_pkg::PROG_NONE};
        end else begin
            lvl_r   <= lvl_nxt;
            nopin_r <= nopin_nxt;
            prog_r  <= prog_nxt;
        end
    end

    // ----------------------------------------------------------------
    // debug mode select
    // ----------------------------------------------------------------
    reset_brownout_protect_ctrl_pkg::dbg_s dbg_r;
    reset_brownout_protect_ctrl_pkg::dbg_s dbg_nxt;

    always_comb begin
        dbg_nxt.bscan_mode  = ~pin_s;
        dbg_nxt.tap_pins_hw = ~pin_s;
        dbg_nxt.jtag_debug  = 1'b0;
        dbg_nxt.swd_en      = pin_s && core_rst_n_nxt
                              && (lvl_nxt == reset_brownout_protect_ctrl_pkg::PROT_NONE);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dbg_r <= '0;
        end else begin
            dbg_r <= dbg_nxt;
        end
    end

    // ----------------------------------------------------------------
    // supply drop interrupt and status
    // ----------------------------------------------------------------
    logic sdd_int_r;
    logic sdd_int_nxt;

    // level follows the supply; the interrupt controller latches it
    always_comb begin
        sdd_int_nxt = 1'b0;
        if (sdd_int_sel < 2'(`SDD_INT_LEVELS)) begin
            sdd_int_nxt = below_int_s[sdd_int_sel];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sdd_int_r <= 1'b0;
        end else begin
            sdd_int_r <= sdd_int_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign osc_en        = osc_en_r;
    assign flash_init    = flash_init_r;
    assign defaults_load = load_r;
    assign core_rst_n    = core_rst_n_r;
    assign boot_addr     = boot_addr_r;
    assign sdd_irq       = sdd_int_r;
    assign sdd_status    = sdd_int_r;
    assign prot_level    = lvl_r;
    assign prog_ctl      = prog_r;
    assign dbg_ctl       = dbg_r;
    assign bkpt_num      = BKPT_NUM[2:0];
    assign wpt_num       = WPT_NUM[1:0];

endmodule : reset_brownout_protect_ctrl

// ===== core/reset_brownout_protect_ctrl_consts.svh
`ifndef RESET_BROWNOUT_PROTECT_CTRL_CONSTS_SVH
`define RESET_BROWNOUT_PROTECT_CTRL_CONSTS_SVH

// ----------------------------------------------------------------
// clock and reset pin timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      5
`define RST_PULSE_MIN_NS   50
// least time, so round up to whole cycles
`define RST_PULSE_CYC      ((`RST_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W          8

// ----------------------------------------------------------------
// processor start and debug resources
// ----------------------------------------------------------------
`define BOOT_FETCH_ADDR    32'h0000_0000
`define DBG_BKPT_NUM       4
`define DBG_WPT_NUM        2

// ----------------------------------------------------------------
// protection patterns held in the dedicated flash word (arbitrary values)
// ----------------------------------------------------------------
`define PROT_ONE_PATTERN   32'hA5C3_0001
`define PROT_TWO_PATTERN   32'hA5C3_0002
`define PROT_THREE_PATTERN 32'hA5C3_0003
`define PROT_NOPIN_PATTERN 32'hA5C3_00F0

// ----------------------------------------------------------------
// supply drop thresholds
// ----------------------------------------------------------------
`define SDD_INT_LEVELS     3

`endif

// ===== core/reset_brownout_protect_ctrl_pkg.sv
package reset_brownout_protect_ctrl_pkg;

    // power-up and reset release sequence
    typedef enum logic [2:0] {
        SQ_WAIT_SUPPLY,
        SQ_OSC_START,
        SQ_FLASH_INIT,
        SQ_LOAD,
        SQ_RUN
    } seq_state_e;

    // protection level decoded from the flash word
    typedef enum logic [1:0] {
        PROT_NONE,
        PROT_ONE,
        PROT_TWO,
        PROT_THREE
    } prot_level_e;

    // which programming commands the serial loader may run
    typedef enum logic [1:0] {
        PROG_ALL,
        PROG_NO_SECTOR0,
        PROG_ERASE_ALL_ONLY,
        PROG_NONE
    } prog_class_e;

    typedef struct packed {
        logic swd_en;       // serial-wire debug port usable
        logic bscan_mode;   // boundary-scan selected
        logic tap_pins_hw;  // test pins owned by hardware
        logic jtag_debug;   // core debug via test port
    } dbg_s;

    typedef struct packed {
        logic        pin_entry_en; // sample programming-entry pin
        logic        app_prog_ok;  // in-application calls allowed
        prog_class_e cmd_class;    // permitted loader commands
    } prog_s;

endpackage : reset_brownout_protect_ctrl_pkg

// ===== core/sync_chain.sv
`timescale 1ns/100ps

// two-flop synchroniser for levels arriving from outside the clock
module sync_chain #(
    parameter int         WIDTH   = 1,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic             clk,      // system clock
    input  wire logic             arst_n,   // async reset
    input  wire logic [WIDTH-1:0] async_in, // raw level
    output logic      [WIDTH-1:0] sync_out  // synchronised level
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // first stage is read only by the second
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RST_VAL[WIDTH-1:0];
            sync_r <= RST_VAL[WIDTH-1:0];
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule : sync_chain

// ===== verification/ext_reset_src.sv
`timescale 1ns/100ps

// reset pin driver; the pin is pulled high unless a pulse is running
module ext_reset_src (
    input  wire logic       clk,     // clock
    input  wire logic       fire,    // start a pulse
    input  wire logic [7:0] low_len, // low time in cycles
    output logic            rst_pin  // reset pin level
);
    logic [7:0] cnt_r = 8'h00;
    // count down the low time, idle high from power-up
    always @(posedge clk) begin
        if (fire) cnt_r <= low_len;
        else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
    assign rst_pin = (cnt_r == 8'h00);
endmodule : ext_reset_src

// ===== verification/rbpc_sva.sv
`timescale 1ns/100ps

// watches the top ports; all in the clock domain
module rbpc_sva (
    input wire logic        clk,           // clock
    input wire logic        arst_n,        // reset
    input wire logic        wdt_rst_req,   // watchdog
    input wire logic        osc_en,        // osc on
    input wire logic        flash_init,    // flash init
    input wire logic        defaults_load, // load pulse
    input wire logic        core_rst_n,    // core reset
    input wire logic [31:0] boot_addr,     // fetch addr
    input wire logic        sdd_irq,       // irq
    input wire logic        sdd_status,    // status
    input wire reset_brownout_protect_ctrl_pkg::prot_level_e prot_level, // level
    input wire reset_brownout_protect_ctrl_pkg::prog_s       prog_ctl,   // loader
    input wire reset_brownout_protect_ctrl_pkg::dbg_s        dbg_ctl,    // debug
    input wire logic [2:0]  bkpt_num,      // breakpoints
    input wire logic [1:0]  wpt_num        // watchpoints
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_wdt_resets: assert property (wdt_rst_req |-> ##2 !core_rst_n)
        else $error("watchdog did not reset");
    a_osc_first: assert property ($rose(flash_init) |-> osc_en)
        else $error("flash init before osc");
    a_boot_zero: assert property (boot_addr == 32'h0000_0000)
        else $error("boot address not zero");
    a_release_loaded: assert property ($rose(core_rst_n) |-> $past(defaults_load))
        else $error("release without load");
    a_load_pulse: assert property (defaults_load |=> !defaults_load)
        else $error("load longer than a cycle");
    a_status_copy: assert property (sdd_status == sdd_irq)
        else $error("status differs from irq");
    a_app_prog: assert property (prog_ctl.app_prog_ok)
        else $error("app programming blocked");
    a_class_level: assert property (2'(prog_ctl.cmd_class) == 2'(prot_level))
        else $error("loader class wrong");
    a_three_nopin: assert property (prot_level == reset_brownout_protect_ctrl_pkg::PROT_THREE
        |-> !prog_ctl.pin_entry_en) else $error("entry pin live at level three");
    a_swd_open: assert property (dbg_ctl.swd_en |-> !dbg_ctl.bscan_mode &&
        prot_level == reset_brownout_protect_ctrl_pkg::PROT_NONE) else $error("swd wrongly on");
    a_swd_reset: assert property (!core_rst_n [*2] |-> !dbg_ctl.swd_en)
        else $error("swd on in reset");
    a_dbg_fixed: assert property (bkpt_num == 3'h4 && wpt_num == 2'h2 && !dbg_ctl.jtag_debug)
        else $error("debug resources wrong");
    // main scenarios reached
    c_release: cover property ($rose(core_rst_n));
    c_swd: cover property (dbg_ctl.swd_en);
    c_irq: cover property ($rose(sdd_irq));
endmodule : rbpc_sva

bind reset_brownout_protect_ctrl rbpc_sva i_sva (.clk, .arst_n, .wdt_rst_req, .osc_en, .flash_init,
    .defaults_load, .core_rst_n, .boot_addr, .sdd_irq, .sdd_status, .prot_level, .prog_ctl,
    .dbg_ctl, .bkpt_num, .wpt_num);

// ===== verification/tb_reset_brownout_protect_ctrl.sv
`timescale 1ns/100ps
`include "reset_brownout_protect_ctrl_consts.svh"

module tb_reset_brownout_protect_ctrl;
    logic clk = 1'b0, arst_n = 1'b0, wdt_rst_req = 1'b0, supply_ok = 1'b0, fire = 1'b0;
    logic sdd_below_rst = 1'b0, sdd_rst_en = 1'b0, osc_ready = 1'b0, flash_ready = 1'b0;
    logic rst_pin, osc_en, flash_init, defaults_load, core_rst_n, sdd_irq, sdd_status;
    logic [2:0] sdd_below_int = 3'h0, bkpt_num;
    logic [1:0] sdd_int_sel = 2'h3, wpt_num;
    logic [7:0] low_len = 8'h00;
    logic [31:0] prot_word = 32'h0000_0000, boot_addr;
    reset_brownout_protect_ctrl_pkg::prot_level_e prot_level;
    reset_brownout_protect_ctrl_pkg::prog_s prog_ctl;
    reset_brownout_protect_ctrl_pkg::dbg_s dbg_ctl;
    int errors = 0, comparisons = 0;

    always #2.5 clk = ~clk;
    reset_brownout_protect_ctrl i_dut (.clk, .arst_n, .rst_pin, .wdt_rst_req, .supply_ok,
        .sdd_below_rst, .sdd_below_int, .sdd_int_sel, .sdd_rst_en, .osc_ready, .flash_ready,
        .prot_word, .osc_en, .flash_init, .defaults_load, .core_rst_n, .boot_addr, .sdd_irq,
        .sdd_status, .prot_level, .prog_ctl, .dbg_ctl, .bkpt_num, .wpt_num);
    ext_reset_src i_pin (.clk, .fire, .low_len, .rst_pin);

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // sample 1 ns after the edge so registered outputs have settled
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        #1;
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_rst(input logic lvl, input int lim);
        for (int n = 0; n < lim && core_rst_n !== lvl; n++) @(posedge clk) #1; // look once settled
        check("core_rst_n", core_rst_n, lvl);
        if (core_rst_n !== lvl) print_verdict();
    endtask : wait_rst

    task automatic pulse(input logic [7:0] len);
        @(posedge clk);
        low_len <= len;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask : pulse

    // power-up with supply, oscillator and flash arriving late
    task automatic boot(input logic [31:0] word);
        @(posedge clk);
        arst_n <= 1'b0;
        {supply_ok, osc_ready, flash_ready} <= 3'h0;
        prot_word <= word;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        check("osc_en idle", osc_en, 1'b0);
        @(posedge clk);
        supply_ok <= 1'b1;
        repeat (5) @(posedge clk);
        check("osc_en", osc_en, 1'b1);
        @(posedge clk);
        osc_ready <= 1'b1;
        repeat (3) @(posedge clk);
        check("flash_init", flash_init, 1'b1);
        check("core held", core_rst_n, 1'b0);
        @(posedge clk);
        flash_ready <= 1'b1;
        wait_rst(1'b1, 20);
        check("boot_addr", boot_addr, 32'h0000_0000);
    endtask : boot

    task automatic t_protect();
        logic [31:0] words [5] = '{`PROT_NOPIN_PATTERN, `PROT_ONE_PATTERN, `PROT_TWO_PATTERN,
                                   `PROT_THREE_PATTERN, 32'h0000_0000};
        logic [3:0] exps [5] = '{4'b0001, 4'b0110, 4'b1010, 4'b1100, 4'b0011};
        for (int i = 0; i < 5; i++) begin
            boot(words[i]);
            repeat (2) @(posedge clk);
            check("prot_level", prot_level, exps[i][3:2]);
            check("cmd_class", prog_ctl.cmd_class, exps[i][3:2]);
            check("pin_entry", prog_ctl.pin_entry_en, exps[i][1]);
            check("swd_en", dbg_ctl.swd_en, exps[i][0]);
        end
        $display("t_protect done");
    endtask : t_protect

    task automatic t_pin();
        pulse(8'h09);
        repeat (30) @(posedge clk);
        check("short pulse", core_rst_n, 1'b1);
        pulse(8'h0A);
        repeat (5) @(posedge clk);
        check("bscan_mode", dbg_ctl.bscan_mode, 1'b1);
        check("tap_pins_hw", dbg_ctl.tap_pins_hw, 1'b1);
        wait_rst(1'b0, 20);
        wait_rst(1'b1, 60);
        repeat (2) @(posedge clk);
        check("swd back", dbg_ctl.swd_en, 1'b1);
        $display("t_pin done");
    endtask : t_pin

    task automatic t_wdt();
        @(posedge clk);
        wdt_rst_req <= 1'b1;
        @(posedge clk);
        wdt_rst_req <= 1'b0;
        wait_rst(1'b0, 3);
        @(posedge clk);
        check("swd in reset", dbg_ctl.swd_en, 1'b0);
        wait_rst(1'b1, 20);
        $display("t_wdt done");
    endtask : t_wdt

    task automatic t_sdd();
        logic [2:0] pat;
        for (int i = 0; i < 8; i++) begin
            pat = i[2] ? 3'b101 : 3'b010;
            @(posedge clk);
            sdd_int_sel <= i[1:0];
            sdd_below_int <= pat;
            repeat (5) @(posedge clk);
            check("sdd_irq", sdd_irq, (i[1:0] == 2'h3) ? 1'b0 : pat[i[1:0]]);
            check("sdd_status", sdd_status, (i[1:0] == 2'h3) ? 1'b0 : pat[i[1:0]]);
        end
        @(posedge clk);
        sdd_below_rst <= 1'b1;
        repeat (30) @(posedge clk);
        check("sdd reset off", core_rst_n, 1'b1);
        @(posedge clk);
        sdd_rst_en <= 1'b1;
        wait_rst(1'b0, 30);
        @(posedge clk);
        sdd_below_rst <= 1'b0;
        wait_rst(1'b1, 60);
        $display("t_sdd done");
    endtask : t_sdd

    // supply loss in run holds the core, return of supply restarts it
    task automatic t_supply();
        @(posedge clk);
        supply_ok <= 1'b0;
        wait_rst(1'b0, 10);
        check("osc kept", osc_en, 1'b1);
        @(posedge clk);
        supply_ok <= 1'b1;
        wait_rst(1'b1, 20);
        $display("t_supply done");
    endtask : t_supply

    initial begin
        t_protect();
        t_pin();
        t_wdt();
        t_sdd();
        t_supply();
        print_verdict();
    end
endmodule : tb_reset_brownout_protect_ctrl
